// File: rtl/pcg_top.sv
// Programmable clock generator: enable, state, config, ready and interrupt logic
`default_nettype none
`include "pcg_map.svh"
module pcg_top #(
   parameter int NUM_CLK = `PCG_NUM_CLK
) (
   // Clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   arst_n_i,
   // Source clocks
   input  wire logic                   slow_clk_i,
   input  wire logic                   main_clk_i,
   input  wire logic                   master_clk_i,
   input  wire logic                   pll_a_output_i,
   input  wire logic                   pll_b_output_i,
   // Enable and disable writes
   input  wire logic                   sysclk_enable_wr_i,
   input  wire logic [NUM_CLK-1:0]     sysclk_enable_mask_i,
   input  wire logic                   sysclk_disable_wr_i,
   input  wire logic [NUM_CLK-1:0]     sysclk_disable_mask_i,
   // Configuration write and readback
   input  wire logic [NUM_CLK-1:0]     progclk_config_wr_i,
   input  wire logic [2:0]             source_select_i,
   input  wire logic [2:0]             prescale_select_i,
   output logic      [NUM_CLK*3-1:0]   source_select_o,
   output logic      [NUM_CLK*3-1:0]   prescale_select_o,
   // Status
   output logic      [NUM_CLK-1:0]     sysclk_state_reg_o,
   output logic      [NUM_CLK-1:0]     progclk_ready_flag_o,
   // Interrupt enable
   input  wire logic                   irq_enable_wr_i,
   input  wire logic                   irq_disable_wr_i,
   input  wire logic [NUM_CLK-1:0]     irq_mask_i,
   output logic      [NUM_CLK-1:0]     power_ctrl_irq_enable_reg_o,
   output logic                        irq_o,
   // Clock outputs
   output logic      [NUM_CLK-1:0]     progclk_output_o
);

   generate
      if (NUM_CLK < 1 || NUM_CLK > 8) begin : g_bad_num
         $error("NUM_CLK must lie between 1 and 8");
      end
   endgenerate

   typedef struct packed {
      logic [`PCG_NUM_SRC-1:0]   meta;
      logic [`PCG_NUM_SRC-1:0]   sync;
      logic [NUM_CLK-1:0]        en;
      logic [NUM_CLK-1:0]        ien;
      logic [NUM_CLK-1:0][2:0]   src;
      logic [NUM_CLK-1:0][2:0]   prescale_select;
      logic                      live;
   } pcg_top_st_t;

   logic [1:0]              rst_sync_r;
   logic                    rst_n;
   pcg_top_st_t             st_r;
   pcg_top_st_t             st_nxt;
   logic [`PCG_NUM_SRC-1:0] src_pins;
   logic [NUM_CLK-1:0]      rdy;
   logic [NUM_CLK-1:0]      clk_out;

   // Reset release through two flip-flops
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_comb begin
      src_pins                 = '0;
      src_pins[`PCG_VEC_SLOW]   = slow_clk_i;
      src_pins[`PCG_VEC_MAIN]   = main_clk_i;
      src_pins[`PCG_VEC_PLLA]   = pll_a_output_i;
      src_pins[`PCG_VEC_PLLB]   = pll_b_output_i;
      src_pins[`PCG_VEC_MASTER] = master_clk_i;
   end

   always_comb begin
      st_nxt       = st_r;
      st_nxt.meta  = src_pins;
      st_nxt.sync  = st_r.meta;
      st_nxt.live  = 1'b1;
      // Disable wins over a simultaneous enable of the same clock
      if (sysclk_enable_wr_i) begin
         st_nxt.en = st_nxt.en | sysclk_enable_mask_i;
      end
      if (sysclk_disable_wr_i) begin
         st_nxt.en = st_nxt.en & ~sysclk_disable_mask_i;
      end
      for (int k = 0; k < NUM_CLK; k++) begin
         if (progclk_config_wr_i[k]) begin
            st_nxt.src[k]  = source_select_i;
            st_nxt.prescale_select[k] = prescale_select_i;
         end
      end
      if (irq_enable_wr_i) begin
         st_nxt.ien = st_nxt.ien | irq_mask_i;
      end
      if (irq_disable_wr_i) begin
         st_nxt.ien = st_nxt.ien & ~irq_mask_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= '0;
         for (int k = 0; k < NUM_CLK; k++) begin
            st_r.src[k]  <= `PCG_SRC_SLOW;
            st_r.prescale_select[k] <= `PCG_PRESCALE_SELECT_RST;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   pcg_if lnk [NUM_CLK] ();

   generate
      for (genvar g = 0; g < NUM_CLK; g++) begin : g_div
         assign lnk[g].en   = st_r.en[g];
         assign lnk[g].src  = st_r.src[g];
         assign lnk[g].prescale_select = st_r.prescale_select[g];
         assign rdy[g]      = lnk[g].rdy;
         assign clk_out[g]  = lnk[g].clk;

         pcg_div u_div (
            .core_clk_i (core_clk_i),
            .rst_n_i    (rst_n),
            .src_vec_i  (st_r.sync),
            .lnk        (lnk[g])
         );
      end
   endgenerate

   assign sysclk_state_reg_o          = st_r.en;
   assign progclk_ready_flag_o        = rdy;
   assign source_select_o             = st_r.src;
   assign prescale_select_o           = st_r.prescale_select;
   assign power_ctrl_irq_enable_reg_o = st_r.ien;
   assign irq_o                       = |(rdy & st_r.ien);
   assign progclk_output_o            = clk_out;

   sequence s_disable_written;
      sysclk_disable_wr_i ##1 1'b1;
   endsequence

   sequence s_enable_only;
      sysclk_enable_wr_i && !sysclk_disable_wr_i;
   endsequence

   chk_reset_state: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !st_r.live |-> (sysclk_state_reg_o == '0) && (source_select_o == '0) && (prescale_select_o == '0)
                     && (progclk_ready_flag_o == '0) && (progclk_output_o == '0) && !irq_o)
      else $error("state after reset not disabled slow divide by one");

   chk_enable_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      s_enable_only |=> (sysclk_state_reg_o & $past(sysclk_enable_mask_i)) == $past(sysclk_enable_mask_i))
      else $error("enable write did not set state bits");

   chk_disable_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      sysclk_disable_wr_i |=> (sysclk_state_reg_o & $past(sysclk_disable_mask_i)) == '0)
      else $error("disable write did not clear state bits");

   chk_state_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !sysclk_enable_wr_i && !sysclk_disable_wr_i |=> $stable(sysclk_state_reg_o))
      else $error("state changed without a write");

   chk_ready_drops: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      s_disable_written ##1 1'b1 |-> (progclk_ready_flag_o & $past(sysclk_disable_mask_i, 2)) == '0)
      else $error("ready flag survived disable");

   chk_ready_needs_en: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (progclk_ready_flag_o & ~$past(sysclk_state_reg_o)) == '0)
      else $error("ready flag without enabled clock");

   chk_irq_raise: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      irq_enable_wr_i && !irq_disable_wr_i && ((progclk_ready_flag_o & sysclk_state_reg_o & irq_mask_i) != '0)
      |=> irq_o)
      else $error("enabled ready flag did not raise interrupt");

   chk_irq_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      irq_disable_wr_i |=> (power_ctrl_irq_enable_reg_o & $past(irq_mask_i)) == '0)
      else $error("interrupt mask bits survived a mask clear");

   chk_cfg_load: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      progclk_config_wr_i[0] |=> (source_select_o[2:0] == $past(source_select_i))
                                 && (prescale_select_o[2:0] == $past(prescale_select_i)))
      else $error("configuration write not taken as one unit");

   chk_cfg_load_last: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      progclk_config_wr_i[NUM_CLK-1] |=> (source_select_o[NUM_CLK*3-1 -: 3] == $past(source_select_i))
                                         && (prescale_select_o[NUM_CLK*3-1 -: 3] == $past(prescale_select_i)))
      else $error("configuration write of last clock not taken as one unit");

   chk_cfg_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      progclk_config_wr_i == '0 |=> $stable(source_select_o) && $stable(prescale_select_o))
      else $error("configuration changed without a write");

   chk_ien_set: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      irq_enable_wr_i && !irq_disable_wr_i |=> (power_ctrl_irq_enable_reg_o & $past(irq_mask_i)) == $past(irq_mask_i))
      else $error("interrupt mask write did not set bits");

   chk_ien_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !irq_enable_wr_i && !irq_disable_wr_i |=> $stable(power_ctrl_irq_enable_reg_o))
      else $error("interrupt mask changed without a write");

   chk_ready_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (~progclk_ready_flag_o & $past(progclk_ready_flag_o) & $past(sysclk_state_reg_o)) == '0)
      else $error("ready flag fell while clock enabled");

   chk_out_needs_en: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (progclk_output_o & ~$past(sysclk_state_reg_o)) == '0)
      else $error("clock output high while disabled");

   chk_sync_two_ff: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      $past(st_r.live) |-> st_r.sync == $past(src_pins, 2))
      else $error("source clocks not passed through two flip-flops");

endmodule
`default_nettype wire

// File: rtl/pcg_map.svh
// Offsets, field codes, reset values and counts of the programmable clock generator
// Summary of operation
// - Three clock outputs, each switched on by enable write and off by disable write.
// - A readable state word shows one enabled bit per clock output.
// - After reset every clock output stays disabled until software enables it.
// - Each clock has a source field: main, slow, master, PLL A or PLL B.
// - The source field of every clock resets to the slow clock.
// - Each clock has a prescaler giving ratios 1, 2, 4, 8, 16, 32, 64.
// - Each output is its selected source divided by the prescaler ratio.
// - Prescaler resets to zero, divide by one, so output equals slow clock.
// - Enabling a configured clock sets its ready flag; software waits for it.
// - Ready flags are polled or raise the interrupt when enabled in the mask.
// - Source and prescaler of a clock are taken together in one write.
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

`define PCG_NUM_CLK    3
`define PCG_NUM_SRC    5

// Source select codes
`define PCG_SRC_SLOW   3'h0
`define PCG_SRC_MAIN   3'h1
`define PCG_SRC_PLLA   3'h2
`define PCG_SRC_PLLB   3'h3
`define PCG_SRC_MASTER 3'h4

// Positions of the sources in the synchronised source vector
`define PCG_VEC_SLOW   0
`define PCG_VEC_MAIN   1
`define PCG_VEC_PLLA   2
`define PCG_VEC_PLLB   3
`define PCG_VEC_MASTER 4

// Prescaler exponent: reset value and largest legal code
`define PCG_PRESCALE_SELECT_RST   3'h0
`define PCG_PRESCALE_SELECT_MAX   3'h6

`endif

// File: rtl/pcg_pkg.sv
// Types shared by the programmable clock generator modules
`default_nettype none
`include "pcg_map.svh"
package pcg_pkg;

   typedef enum logic [2:0] {
      PCG_SRC_SLOW_E   = `PCG_SRC_SLOW,
      PCG_SRC_MAIN_E   = `PCG_SRC_MAIN,
      PCG_SRC_PLLA_E   = `PCG_SRC_PLLA,
      PCG_SRC_PLLB_E   = `PCG_SRC_PLLB,
      PCG_SRC_MASTER_E = `PCG_SRC_MASTER
   } pcg_src_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic       prev;
      logic       out;
      logic       rdy;
   } pcg_div_st_t;

endpackage
`default_nettype wire

// File: rtl/pcg_if.sv
// Link between the control logic and one clock divider
`default_nettype none
interface pcg_if;
   logic [2:0] src;
   logic [2:0] prescale_select;
   logic       en;
   logic       rdy;
   logic       clk;

   modport ctrl (output src, output prescale_select, output en, input rdy, input clk);
   modport gen  (input src, input prescale_select, input en, output rdy, output clk);
endinterface
`default_nettype wire

// File: rtl/pcg_div.sv
// One programmable clock divider working on edges of synchronised source clocks
`default_nettype none
`include "pcg_map.svh"
module pcg_div (
   // Clock and reset
   input  wire logic                    core_clk_i,
   input  wire logic                    rst_n_i,
   // Synchronised source clocks
   input  wire logic [`PCG_NUM_SRC-1:0] src_vec_i,
   // Control link
   pcg_if.gen                           lnk
);

   pcg_pkg::pcg_div_st_t st_r;
   pcg_pkg::pcg_div_st_t st_nxt;
   logic                 sel;
   logic                 rise;

   function automatic logic pick(input logic [2:0] code, input logic [`PCG_NUM_SRC-1:0] vec);
      pick = 1'b0;
      case (pcg_pkg::pcg_src_t'(code))
         pcg_pkg::PCG_SRC_SLOW_E:   pick = vec[`PCG_VEC_SLOW];
         pcg_pkg::PCG_SRC_MAIN_E:   pick = vec[`PCG_VEC_MAIN];
         pcg_pkg::PCG_SRC_PLLA_E:   pick = vec[`PCG_VEC_PLLA];
         pcg_pkg::PCG_SRC_PLLB_E:   pick = vec[`PCG_VEC_PLLB];
         pcg_pkg::PCG_SRC_MASTER_E: pick = vec[`PCG_VEC_MASTER];
         default:                   pick = 1'b0;
      endcase
   endfunction

   // Source edges per half period, minus one; reserved code counts as the largest ratio
   function automatic logic [4:0] half_lim(input logic [2:0] p);
      logic [2:0] e;
      e = (p > `PCG_PRESCALE_SELECT_MAX) ? `PCG_PRESCALE_SELECT_MAX : p;
      half_lim = 5'((6'h01 << (e - 3'h1)) - 6'h01);
   endfunction

   always_comb begin
      sel        = pick(lnk.src, src_vec_i);
      rise       = sel & ~st_r.prev;
      st_nxt     = st_r;
      st_nxt.prev = sel;
      if (!lnk.en) begin
         st_nxt.cnt = 5'h00;
         st_nxt.out = 1'b0;
         st_nxt.rdy = 1'b0;
      end else if (lnk.prescale_select == `PCG_PRESCALE_SELECT_RST) begin
         if (rise) begin
            st_nxt.rdy = 1'b1;
         end
         st_nxt.out = sel & st_nxt.rdy;
      end else if (rise) begin
         if (st_r.cnt >= half_lim(lnk.prescale_select)) begin
            st_nxt.cnt = 5'h00;
            st_nxt.out = ~st_r.out;
            st_nxt.rdy = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lnk.clk = st_r.out;
   assign lnk.rdy = st_r.rdy;

   chk_out_low_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !lnk.en |=> !lnk.clk && !lnk.rdy)
      else $error("clock output not low while disabled");

   chk_out_on_edge: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $changed(st_r.out) && $past(lnk.en) && ($past(lnk.prescale_select) != 3'h0) |-> $past(rise))
      else $error("divided output moved without a source edge");

   chk_div1_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      lnk.en && (lnk.prescale_select == 3'h0) && st_r.rdy ##1 lnk.en && $stable(lnk.prescale_select) |-> lnk.clk == $past(sel))
      else $error("divide by one output does not follow source");

endmodule
`default_nettype wire

// File: test/pcg_src_model.sv
// Free-running source clocks standing in for the oscillators and PLLs
`default_nettype none
module pcg_src_model (
   // Source clocks, all slower than half the core clock
   output var logic slow_o,
   output var logic main_o,
   output var logic pll_a_o,
   output var logic pll_b_o,
   output var logic master_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Periods follow the source code: 200 ns plus 80 ns per code step
   // Odd start offset keeps every source edge off the core clock edges
   initial begin
      slow_o   = 1'b0;
      main_o   = 1'b0;
      pll_a_o  = 1'b0;
      pll_b_o  = 1'b0;
      master_o = 1'b0;
      #7;
      fork
         forever #100 slow_o = ~slow_o;
         forever #140 main_o = ~main_o;
         forever #180 pll_a_o = ~pll_a_o;
         forever #220 pll_b_o = ~pll_b_o;
         forever #260 master_o = ~master_o;
      join
   end
endmodule
`default_nettype wire

// File: test/programmable_clock_generator_test.sv
// Self-checking bench of the programmable clock generator
`default_nettype none
module programmable_clock_generator_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 1'b0;
   logic        arst_n_i   = 1'b0;
   logic        slow, main, mstr, pla, plb, irq;
   logic        en_wr      = 1'b0;
   logic        dis_wr     = 1'b0;
   logic        ie_wr      = 1'b0;
   logic        id_wr      = 1'b0;
   logic [2:0]  en_m       = 3'h0;
   logic [2:0]  dis_m      = 3'h0;
   logic [2:0]  ir_m       = 3'h0;
   logic [2:0]  cfg_wr     = 3'h0;
   logic [2:0]  src        = 3'h0;
   logic [2:0]  prescale_select       = 3'h0;
   logic [8:0]  src_rb, prescale_select_rb;
   logic [2:0]  state, rdy, ie_reg, outc;
   logic [31:0] rnd        = 32'h84898131;
   int          err_count  = 0;
   int          checks     = 0;

   pcg_src_model src_u (.slow_o(slow), .main_o(main), .pll_a_o(pla), .pll_b_o(plb), .master_o(mstr));

   pcg_top dut_u (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .slow_clk_i(slow), .main_clk_i(main), .master_clk_i(mstr),
      .pll_a_output_i(pla), .pll_b_output_i(plb),
      .sysclk_enable_wr_i(en_wr), .sysclk_enable_mask_i(en_m),
      .sysclk_disable_wr_i(dis_wr), .sysclk_disable_mask_i(dis_m),
      .progclk_config_wr_i(cfg_wr), .source_select_i(src), .prescale_select_i(prescale_select),
      .source_select_o(src_rb), .prescale_select_o(prescale_select_rb),
      .sysclk_state_reg_o(state), .progclk_ready_flag_o(rdy),
      .irq_enable_wr_i(ie_wr), .irq_disable_wr_i(id_wr), .irq_mask_i(ir_m),
      .power_ctrl_irq_enable_reg_o(ie_reg), .irq_o(irq), .progclk_output_o(outc)
   );

   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Output period: source period scaled by two to the prescaler exponent
   function automatic realtime exp_per(input logic [2:0] s, input logic [2:0] p);
      // Reserved code 7 divides as the largest ratio
      return (200.0 + 80.0 * s) * (1 << ((p > 3'h6) ? 3'h6 : p));
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Op 0 enable, 1 disable, 2 irq enable, 3 irq disable, 4 enable and disable together
   task automatic strobe(input int op, input logic [2:0] m);
      @(posedge core_clk_i);
      en_m   <= m;
      dis_m  <= m;
      ir_m   <= m;
      en_wr  <= (op == 0 || op == 4);
      dis_wr <= (op == 1 || op == 4);
      ie_wr  <= (op == 2);
      id_wr  <= (op == 3);
      @(posedge core_clk_i);
      en_wr  <= 1'b0;
      dis_wr <= 1'b0;
      ie_wr  <= 1'b0;
      id_wr  <= 1'b0;
   endtask

   task automatic rise_time(input int k, output realtime t);
      logic pv;
      int   n;
      pv = outc[k];
      n  = 0;
      t  = 0.0;
      while (n < 3000) begin
         @(posedge core_clk_i);
         #1;
         if (outc[k] && !pv) begin
            t = $realtime;
            break;
         end
         pv = outc[k];
         n++;
      end
      check("edge_seen", 32'(n < 3000), 32'h1);
   endtask

   initial begin
      #3_000_000;
      err_count++;
      end_sim;
   end

   initial begin
      int         k;
      int         n;
      realtime    t0, t1, d;
      logic [2:0] m, s, p;
      logic       hi;
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1;
      check("state_rst", state, 32'h0);
      check("src_rst", src_rb, 32'h0);
      check("prescale_select_rst", prescale_select_rb, 32'h0);
      check("rdy_out_rst", {rdy, irq, outc}, 32'h0);
      strobe(4, 3'h7);
      @(posedge core_clk_i);
      #1;
      check("en_dis_same", state, 32'h0);
      for (int i = 0; i < 10; i++) begin
         rnd = lfsr(rnd);
         // Early passes cover every clock, source and prescaler code, reserved 7 too
         k   = (i < 3) ? i : int'(rnd % 32'h3);
         m   = 3'h1 << k;
         s   = 3'(i < 7 ? i % 5 : rnd[7:4] % 5);
         p   = 3'(i < 8 ? i : rnd[12:10] % 7);
         // The clock is disabled here, so the new setting may be written
         @(posedge core_clk_i);
         cfg_wr <= m;
         src    <= s;
         prescale_select   <= p;
         @(posedge core_clk_i);
         cfg_wr <= 3'h0;
         @(posedge core_clk_i);
         #1;
         check("src_rb", src_rb[3*k+:3], s);
         check("prescale_select_rb", prescale_select_rb[3*k+:3], p);
         if (i % 4 == 1)
            strobe(2, m);
         strobe(0, m);
         @(posedge core_clk_i);
         #1;
         check("state_on", state, m);
         n = 0;
         while (!rdy[k] && n < 2000) begin
            @(posedge core_clk_i);
            #1;
            n++;
         end
         check("ready", rdy[k], 32'h1);
         // Unmasking an already ready clock must raise the interrupt too
         if (i % 4 == 3) begin
            strobe(2, m);
            #1;
         end
         check("irq_on", irq, 32'(i % 2));
         check("ie_reg_on", ie_reg, (i % 2 == 1) ? m : 3'h0);
         rise_time(k, t0);
         rise_time(k, t1);
         d = t1 - t0 - exp_per(s, p);
         check("period", 32'(d <= 80.0 && d >= -80.0), 32'h1);
         strobe(3, m);
         @(posedge core_clk_i);
         #1;
         check("irq_off", {ie_reg, irq}, 32'h0);
         strobe(1, m);
         @(posedge core_clk_i);
         #1;
         check("state_off", state, 32'h0);
         @(posedge core_clk_i);
         #1;
         check("rdy_off", rdy[k], 32'h0);
         hi = 1'b0;
         repeat (40) begin
            @(posedge core_clk_i);
            #1;
            hi |= outc[k];
         end
         check("out_held", hi, 32'h0);
      end
      // Unused source code: the output never becomes ready
      @(posedge core_clk_i);
      cfg_wr <= 3'h1;
      src    <= 3'h5;
      prescale_select   <= 3'h0;
      @(posedge core_clk_i);
      cfg_wr <= 3'h0;
      strobe(0, 3'h1);
      hi = 1'b0;
      repeat (40) begin
         @(posedge core_clk_i);
         #1;
         hi |= rdy[0] | outc[0];
      end
      check("bad_src", hi, 32'h0);
      strobe(1, 3'h1);
      end_sim;
   end
endmodule
`default_nettype wire
